// ---- bench/ptr_responder_test.sv ----
// Self-checking bench for the test parameter read responder
`timescale 1ns/100ps

module ptr_responder_test import ptr_pkg::*;;
  logic sys_clk = 0, rst = 1, ce = 1, cmd_valid = 0, cmd_last = 0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, tx_last, tx_valid, tx_ready, busy;
  logic [7:0] tx_data;
  logic downstream_dir = 0, improved_rate_mode = 0, scalar_read_supported = 0;
  logic impulse_protection_supported = 0, robust_margin_supported = 0;
  logic [BANDS-1:0] band_enable = 5'h00;
  logic [1:0] bearer_enable = 2'h0, stall_mode = 2'h0;
  logic [FIELD_W-1:0] loop_loss_value = '0, signal_loss_value = '0, per_band_margin = '0;
  logic [15:0] overall_margin = 16'h0000, achieved_impulse_protection = 16'h0000;
  logic [15:0] actual_aggregate_tx_power_near = 16'h0000;
  logic [15:0] actual_aggregate_tx_power_far = 16'h0000, robust_channel_margin = 16'h0000;
  logic [31:0] attainable_rate = 32'h00000000, seed = 32'h0000004F;
  logic [7:0] attainable_rate_impulse_protection_0 = 8'h00, attainable_rate_delay_0 = 8'h00;
  logic [GROUP_SIZE_W-1:0] group_size = 8'h00;
  logic [GROUP_IDX_W-1:0] group_index = 9'h000;
  logic [SC_IDX_W-1:0] subcarrier_index;
  logic [7:0] req [5];
  logic [8:0] exp_q [$], got_q [$];
  logic pv = 0;
  logic [8:0] pd;
  int miscompares = 0, compares = 0;
  int ml [6] = '{3, 1, 2, 4, 5, 2};
  logic [7:0] mc [6] = '{8'h01, 8'h01, 8'h07, 8'h07, 8'h07, 8'h05};

  ptr_responder DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_last(cmd_last), .cmd_ready(cmd_ready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .downstream_dir(downstream_dir), .band_enable(band_enable),
    .improved_rate_mode(improved_rate_mode), .scalar_read_supported(scalar_read_supported),
    .impulse_protection_supported(impulse_protection_supported),
    .robust_margin_supported(robust_margin_supported), .loop_loss_value(loop_loss_value),
    .signal_loss_value(signal_loss_value), .overall_margin(overall_margin),
    .per_band_margin(per_band_margin), .attainable_rate(attainable_rate),
    .attainable_rate_impulse_protection_0(attainable_rate_impulse_protection_0),
    .attainable_rate_delay_0(attainable_rate_delay_0),
    .actual_aggregate_tx_power_near(actual_aggregate_tx_power_near),
    .actual_aggregate_tx_power_far(actual_aggregate_tx_power_far),
    .achieved_impulse_protection(achieved_impulse_protection),
    .bearer_enable(bearer_enable), .robust_channel_margin(robust_channel_margin),
    .group_size(group_size), .group_index(group_index),
    .subcarrier_index(subcarrier_index), .busy(busy));

  ptr_tx_sink sink (.sys_clk(sys_clk), .rst(rst), .stall_mode(stall_mode),
    .tx_ready(tx_ready));

  // Clock at 200 MHz
  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [79:0] r80();
    logic [95:0] t;
    t = {rnd(), rnd(), rnd()};
    return t[79:0];
  endfunction : r80

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // Record taken octets; a stalled octet must not change before it is taken
  always @(posedge sys_clk) begin
    if (pv)
      check({23'h0, tx_last, tx_data}, {23'h0, pd}, "stalled octet held");
    pv <= !rst && tx_valid && !(tx_ready && ce);
    pd <= {tx_last, tx_data};
    if (!rst && tx_valid && tx_ready && ce)
      got_q.push_back({tx_last, tx_data});
  end

  function automatic void put(logic [7:0] b);
    exp_q.push_back({1'b0, b});
  endfunction : put

  function automatic void put16(logic [15:0] w);
    put(w[15:8]);
    put(w[7:0]);
  endfunction : put16

  // Downstream slot k carries band k+1; the last slot is reserved zero
  function automatic void band(logic [79:0] v);
    logic [15:0] w;
    for (int k = 0; k < 5; k++) begin
      if (downstream_dir)
        w = (k < 4 && band_enable[k+1]) ? v[16*k+16 +: 16] : DISABLED_BAND;
      else
        w = band_enable[k] ? v[16*k +: 16] : DISABLED_BAND;
      put16(w);
    end
  endfunction : band

  function automatic void rate();
    put16(attainable_rate[31:16]);
    put16(attainable_rate[15:0]);
    if (improved_rate_mode) begin
      put(RESERVED_OCTET);
      put(attainable_rate_impulse_protection_0);
      put(RESERVED_OCTET);
      put(attainable_rate_delay_0);
    end
  endfunction : rate

  // Expected response for the request held in req, n octets long
  function automatic void expect_resp(int n);
    logic [7:0] id;
    bit ok;
    id = req[2];
    ok = req[1] == CMD_SCALAR && n == 3 && scalar_read_supported
      && ((id >= ID_LOOP_LOSS && id <= ID_FAR_POWER)
      || (id == ID_IMPULSE && impulse_protection_supported)
      || (id == ID_ROBUST && robust_margin_supported));
    put(req[0]);
    if (req[1] == CMD_SINGLE && n == 2) begin
      put(ACK_SINGLE);
      band(loop_loss_value);
      band(signal_loss_value);
      put16(overall_margin);
      band(per_band_margin);
      rate();
      put16(actual_aggregate_tx_power_near);
      put16(actual_aggregate_tx_power_far);
    end else if (ok) begin
      put(ACK_SCALAR);
      case (id)
        ID_LOOP_LOSS: band(loop_loss_value);
        ID_SIGNAL_LOSS: band(signal_loss_value);
        ID_MARGIN: begin
          put16(overall_margin);
          band(per_band_margin);
        end
        ID_RATE: rate();
        ID_NEAR_POWER: put16(actual_aggregate_tx_power_near);
        ID_FAR_POWER: put16(actual_aggregate_tx_power_far);
        ID_IMPULSE: begin
          put(bearer_enable[0] ? achieved_impulse_protection[15:8] : DISABLED_BEARER);
          put(bearer_enable[1] ? achieved_impulse_protection[7:0] : DISABLED_BEARER);
        end
        default: put16(robust_channel_margin);
      endcase
    end else
      put(NACK_CODE);
    exp_q[exp_q.size()-1][8] = 1'b1;
  endfunction : expect_resp

  task automatic rand_vals;
    logic [31:0] r;
    r = rnd();
    band_enable <= r[4:0];
    bearer_enable <= r[6:5];
    req[0] = r[15:8];
    overall_margin <= r[31:16];
    loop_loss_value <= r80();
    signal_loss_value <= r80();
    per_band_margin <= r80();
    attainable_rate <= rnd();
    r = rnd();
    {attainable_rate_impulse_protection_0, attainable_rate_delay_0} <= r[15:0];
    achieved_impulse_protection <= r[31:16];
    {req[3], req[4]} = r[31:16];
    r = rnd();
    {actual_aggregate_tx_power_near, actual_aggregate_tx_power_far} <= r;
    robust_channel_margin <= r[23:8];
  endtask : rand_vals

  // Offer n octets, each held until an edge that samples cmd_ready high
  task automatic send(int n);
    int t;
    for (int i = 0; i < n; i++) begin
      cmd_data <= req[i];
      cmd_valid <= 1'b1;
      cmd_last <= (i == n - 1);
      t = 0;
      do begin
        @(negedge sys_clk);
        t++;
      end while (cmd_ready !== 1'b1 && t < 3000);
      if (t >= 3000) begin
        miscompares++;
        report_and_stop;
      end
      @(posedge sys_clk);
    end
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
    @(posedge sys_clk);
    expect_resp(n);
  endtask : send

  task automatic drain(string nm);
    int t;
    t = 0;
    while (got_q.size() < exp_q.size() && t < 3000) begin
      @(posedge sys_clk);
      t++;
    end
    repeat (40) @(posedge sys_clk);
    check(got_q.size(), exp_q.size(), "response length");
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
      check({23'h0, got_q[i]}, {23'h0, exp_q[i]}, "response octet");
    got_q.delete();
    exp_q.delete();
    $display("Test %s done", nm);
  endtask : drain

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Single reads: basic upstream with random stalls, improved downstream filling the FIFO
    for (int m = 0; m < 2; m++) begin
      rand_vals;
      downstream_dir <= m[0];
      improved_rate_mode <= m[0];
      stall_mode <= m[0] ? 2'h2 : 2'h1;
      // Corner: upstream band 1 disabled must read as zero
      if (m == 0) begin
        @(posedge sys_clk);
        band_enable <= 5'h1D;
      end
      req[1] = CMD_SINGLE;
      send(2);
      drain("single read");
    end
    // Scalar reads over every identifier, optional ones off then on
    stall_mode <= 2'h1;
    scalar_read_supported <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int id = 32; id <= 41; id++) begin
        rand_vals;
        impulse_protection_supported <= p[0];
        robust_margin_supported <= p[0];
        improved_rate_mode <= p[0];
        // Corner: bearer 0 disabled on the impulse protection read
        if (id == 39) begin
          @(posedge sys_clk);
          bearer_enable <= 2'h2;
        end
        req[1] = CMD_SCALAR;
        req[2] = id[7:0];
        send(3);
      end
      drain("scalar read");
    end
    // Malformed requests and unsupported scalar read
    stall_mode <= 2'h0;
    req[2] = ID_LOOP_LOSS;
    for (int i = 0; i < 6; i++) begin
      req[1] = mc[i];
      send(ml[i]);
    end
    scalar_read_supported <= 1'b0;
    req[1] = CMD_SCALAR;
    send(3);
    drain("malformed");
    // Back-to-back requests: second waits while the first is answered
    rand_vals;
    req[1] = CMD_SINGLE;
    send(2);
    check({30'h0, busy, cmd_ready}, 32'h2, "busy refuses");
    // Clock enable low in mid-response: nothing may be lost or repeated
    repeat (5) @(posedge sys_clk);
    ce <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({30'h0, busy, cmd_ready}, 32'h2, "frozen while ce low");
    ce <= 1'b1;
    send(2);
    drain("back to back");
    // Subcarrier index at boundary and random group values
    for (int i = 0; i < 4; i++) begin
      group_size <= i == 0 ? 8'hFF : GROUP_SIZE_W'(rnd());
      group_index <= i == 0 ? 9'h1FF : GROUP_IDX_W'(rnd());
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check(subcarrier_index, group_size * group_index, "subcarrier index");
      @(posedge sys_clk);
    end
    $display("Test subcarrier done");
    report_and_stop;
  end

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    report_and_stop;
  end
endmodule : ptr_responder_test

// ---- bench/ptr_tx_sink.sv ----
// Transmitter-side sink that accepts response octets, with stalls
`timescale 1ns/100ps

module ptr_tx_sink (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] stall_mode,
  output logic tx_ready
);
  logic [31:0] seed_reg;
  logic [4:0] hold_reg;

  // ready with stalls
  // Mode 0 always ready, 1 random, 2 one octet per 32 cycles so the FIFO fills
  always @(posedge sys_clk) begin
    if (rst) begin
      seed_reg <= 32'h00000017;
      hold_reg <= 5'h00;
      tx_ready <= 1'b0;
    end else begin
      seed_reg <= seed_reg ^ (seed_reg << 5) ^ (seed_reg >> 3);
      hold_reg <= hold_reg + 5'h01;
      case (stall_mode)
        2'h0: tx_ready <= 1'b1;
        2'h1: tx_ready <= seed_reg[3];
        default: tx_ready <= (hold_reg == 5'h00);
      endcase
    end
  end
endmodule : ptr_tx_sink

// ---- verilog/ptr_pkg.sv ----
// Constants and types for the test parameter read responder
package ptr_pkg;
  // Octet and field geometry
  localparam int OCTET_W = 8;
  localparam int BANDS = 5;
  localparam int BAND_W = 16;
  localparam int FIELD_W = BANDS * BAND_W;
  localparam int PAYLOAD_W = 352;
  localparam int RESP_W = PAYLOAD_W + 2 * OCTET_W;
  localparam int FIFO_W = OCTET_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam int GROUP_SIZE_W = 8;
  localparam int GROUP_IDX_W = 9;
  localparam int SC_IDX_W = GROUP_SIZE_W + GROUP_IDX_W;

  // Read command codes in octet 2 of a request
  localparam logic [7:0] CMD_SINGLE = 8'h01;
  localparam logic [7:0] CMD_SCALAR = 8'h07;

  // Response codes in octet 2 of a response
  localparam logic [7:0] ACK_SINGLE = 8'h81;
  localparam logic [7:0] ACK_SCALAR = 8'h87;
  localparam logic [7:0] NACK_CODE = 8'h80;

  // Test parameter identifiers
  localparam logic [7:0] ID_LOOP_LOSS = 8'h21;
  localparam logic [7:0] ID_SIGNAL_LOSS = 8'h22;
  localparam logic [7:0] ID_MARGIN = 8'h23;
  localparam logic [7:0] ID_RATE = 8'h24;
  localparam logic [7:0] ID_NEAR_POWER = 8'h25;
  localparam logic [7:0] ID_FAR_POWER = 8'h26;
  localparam logic [7:0] ID_IMPULSE = 8'h27;
  localparam logic [7:0] ID_ROBUST = 8'h28;

  // Request lengths in octets
  localparam logic [2:0] REQ_LEN_SINGLE = 3'h2;
  localparam logic [2:0] REQ_LEN_SCALAR = 3'h3;
  localparam logic [2:0] REQ_LEN_MAX = 3'h4;

  // Response lengths in octets; single read totals include the header, field lengths do not
  localparam logic [5:0] LEN_HDR = 6'h02;
  localparam logic [5:0] LEN_SINGLE_BASIC = 6'h2A;
  localparam logic [5:0] LEN_SINGLE_IMPR = 6'h2E;
  localparam logic [5:0] LEN_BAND = 6'h0A;
  localparam logic [5:0] LEN_MARGIN = 6'h0C;
  localparam logic [5:0] LEN_RATE_BASIC = 6'h04;
  localparam logic [5:0] LEN_RATE_IMPR = 6'h08;
  localparam logic [5:0] LEN_TWO = 6'h02;

  // Fill values
  localparam logic [7:0] RESERVED_OCTET = 8'h00;
  localparam logic [15:0] DISABLED_BAND = 16'h0000;
  localparam logic [7:0] DISABLED_BEARER = 8'hFF;

  typedef enum logic [1:0] {
    PTR_IDLE = 2'b00,
    PTR_DECIDE = 2'b01,
    PTR_EMIT = 2'b10
  } ptr_state_t;
endpackage : ptr_pkg

// ---- verilog/ptr_responder.sv ----
// Test parameter read responder with its output octet FIFO
// Operation
// R01: every read command gets a response
// R02: malformed command answered with negative acknowledge
// R03: reads never disturb other unit functions
// R04: single read carries IDs 21..26 ascending
// R05: multi-octet values sent most significant first
// R06: band fields are five 2-octet values
// R07: upstream bands 0-4, downstream 1-4 plus reserved
// R08: disabled band reported as zero
// R09: reserved octets sent zero, ignored on receipt
// R10: overall margin precedes five per-band margins
// R11: rate layout basic or improved, rate first
// R12: improved layout: zeros, protection, zero, delay
// R13: scalar request names ID in third octet
// R14: scalar answered only if supported, else negative
// R15: scalar fields match single read layout
// R16: impulse protection is two 1-octet values
// R17: disabled bearer reported as FF
// R18: reserved IDs get no response content
// R19: subcarrier index is group size times index
// R20: code 81 single, 87 scalar, 80 negative
// R21: bearer 0 octet first, bearer 1 second
// R22: length is two plus payload length
// R23: octets held on valid until ready
// R24: one command at a time
`timescale 1ns/100ps

module ptr_fifo import ptr_pkg::*; #(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic push, pop;

  // Extra pointer bit tells full from empty
  always_comb begin
    in_ready = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
    out_valid = (wr_reg != rd_reg);
    push = ce && in_valid && in_ready;
    pop = ce && out_valid && out_ready;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    out_data = mem[rd_reg[AW-1:0]];
  end

  // Pointers and storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      if (push) begin
        mem[wr_reg[AW-1:0]] <= in_data;
      end
    end
  end
endmodule : ptr_fifo

module ptr_responder import ptr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic downstream_dir,
  input wire logic [BANDS-1:0] band_enable,
  input wire logic improved_rate_mode,
  input wire logic scalar_read_supported,
  input wire logic impulse_protection_supported,
  input wire logic robust_margin_supported,
  input wire logic [FIELD_W-1:0] loop_loss_value,
  input wire logic [FIELD_W-1:0] signal_loss_value,
  input wire logic [15:0] overall_margin,
  input wire logic [FIELD_W-1:0] per_band_margin,
  input wire logic [31:0] attainable_rate,
  input wire logic [7:0] attainable_rate_impulse_protection_0,
  input wire logic [7:0] attainable_rate_delay_0,
  input wire logic [15:0] actual_aggregate_tx_power_near,
  input wire logic [15:0] actual_aggregate_tx_power_far,
  input wire logic [15:0] achieved_impulse_protection,
  input wire logic [1:0] bearer_enable,
  input wire logic [15:0] robust_channel_margin,
  input wire logic [GROUP_SIZE_W-1:0] group_size,
  input wire logic [GROUP_IDX_W-1:0] group_index,
  output logic [SC_IDX_W-1:0] subcarrier_index,
  output logic busy
);
  ptr_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] type_reg, type_next, sub_reg, sub_next, id_reg, id_next;
  logic [RESP_W-1:0] resp_reg, resp_next;
  logic [5:0] left_reg, left_next;
  logic [SC_IDX_W-1:0] sc_idx_reg, sc_idx_next;
  logic [FIELD_W-1:0] loop_f, signal_f, margin_f;
  logic [95:0] rate_tail;
  logic [15:0] impulse_f;
  logic [PAYLOAD_W-1:0] pay_single, pay_scalar;
  logic [5:0] len_scalar;
  logic id_known, single_ok, scalar_ok;
  logic [7:0] code_sel;
  logic [5:0] len_sel;
  logic [PAYLOAD_W-1:0] pay_sel;
  logic fifo_in_valid, fifo_in_ready;
  logic [FIFO_W-1:0] fifo_in_data, fifo_out_data;

  // Builds one 5-slot band field; slot order depends on direction
  function automatic logic [FIELD_W-1:0] ptr_bands(input logic [FIELD_W-1:0] vals,
      input logic [BANDS-1:0] en, input logic down);
    logic [FIELD_W-1:0] f;
    f = '0;
    for (int k = 0; k < BANDS; k++) begin
      // R07 slot to band map
      if (!down) begin
        // R08 disabled band zero
        f[FIELD_W-1-BAND_W*k -: BAND_W] = en[k] ? vals[BAND_W*k +: BAND_W] : DISABLED_BAND;
      end else if (k < BANDS - 1) begin
        f[FIELD_W-1-BAND_W*k -: BAND_W] =
          en[k+1] ? vals[BAND_W*(k+1) +: BAND_W] : DISABLED_BAND;
      end
    end
    return f;
  endfunction : ptr_bands

  // Field assembly; values are placed MSB first by concatenation
  always_comb begin
    // R06 five band values
    loop_f = ptr_bands(loop_loss_value, band_enable, downstream_dir);
    signal_f = ptr_bands(signal_loss_value, band_enable, downstream_dir);
    margin_f = ptr_bands(per_band_margin, band_enable, downstream_dir);
    // R11 rate layout select
    // R12 improved rate octets
    if (improved_rate_mode) begin
      rate_tail = {attainable_rate, RESERVED_OCTET, attainable_rate_impulse_protection_0,
                   RESERVED_OCTET, attainable_rate_delay_0,
                   actual_aggregate_tx_power_near, actual_aggregate_tx_power_far};
    end else begin
      rate_tail = {attainable_rate, actual_aggregate_tx_power_near,
                   actual_aggregate_tx_power_far, 32'h0000_0000};
    end
    // R16 two bearer octets
    // R17 disabled bearer FF
    // R21 bearer 0 first
    impulse_f = {bearer_enable[0] ? achieved_impulse_protection[15:8] : DISABLED_BEARER,
                 bearer_enable[1] ? achieved_impulse_protection[7:0] : DISABLED_BEARER};
    // R04 ascending ID order
    // R05 most significant first
    // R10 overall margin first
    pay_single = {loop_f, signal_f, overall_margin, margin_f, rate_tail};
  end

  // Scalar payloads are left aligned so emission is the same shift
  always_comb begin
    pay_scalar = '0;
    len_scalar = LEN_HDR;
    id_known = 1'b1;
    // R15 same layout as single
    // R18 reserved IDs refused
    case (id_reg)
      ID_LOOP_LOSS: begin
        pay_scalar = {loop_f, {(PAYLOAD_W-FIELD_W){1'b0}}};
        len_scalar = LEN_HDR + LEN_BAND;
      end
      ID_SIGNAL_LOSS: begin
        pay_scalar = {signal_f, {(PAYLOAD_W-FIELD_W){1'b0}}};
        len_scalar = LEN_HDR + LEN_BAND;
      end
      ID_MARGIN: begin
        pay_scalar = {overall_margin, margin_f, {(PAYLOAD_W-FIELD_W-16){1'b0}}};
        len_scalar = LEN_HDR + LEN_MARGIN;
      end
      ID_RATE: begin
        pay_scalar = {rate_tail[95:32], {(PAYLOAD_W-64){1'b0}}};
        len_scalar = LEN_HDR + (improved_rate_mode ? LEN_RATE_IMPR : LEN_RATE_BASIC);
        if (!improved_rate_mode) begin
          pay_scalar[PAYLOAD_W-33 -: 32] = 32'h0000_0000;
        end
      end
      ID_NEAR_POWER: begin
        pay_scalar = {actual_aggregate_tx_power_near, {(PAYLOAD_W-16){1'b0}}};
        len_scalar = LEN_HDR + LEN_TWO;
      end
      ID_FAR_POWER: begin
        pay_scalar = {actual_aggregate_tx_power_far, {(PAYLOAD_W-16){1'b0}}};
        len_scalar = LEN_HDR + LEN_TWO;
      end
      ID_IMPULSE: begin
        pay_scalar = {impulse_f, {(PAYLOAD_W-16){1'b0}}};
        len_scalar = LEN_HDR + LEN_TWO;
        id_known = impulse_protection_supported;
      end
      ID_ROBUST: begin
        pay_scalar = {robust_channel_margin, {(PAYLOAD_W-16){1'b0}}};
        len_scalar = LEN_HDR + LEN_TWO;
        id_known = robust_margin_supported;
      end
      default: id_known = 1'b0;
    endcase
  end

  // Response selection from the captured request
  always_comb begin
    // R02 format check
    single_ok = (sub_reg == CMD_SINGLE) && (cnt_reg == REQ_LEN_SINGLE);
    // R13 ID from third octet
    // R14 scalar support gate
    scalar_ok = (sub_reg == CMD_SCALAR) && (cnt_reg == REQ_LEN_SCALAR)
                && scalar_read_supported && id_known;
    // R20 response code
    // R22 total length
    if (single_ok) begin
      code_sel = ACK_SINGLE;
      len_sel = improved_rate_mode ? LEN_SINGLE_IMPR : LEN_SINGLE_BASIC;
      pay_sel = pay_single;
    end else if (scalar_ok) begin
      code_sel = ACK_SCALAR;
      len_sel = len_scalar;
      pay_sel = pay_scalar;
    end else begin
      code_sel = NACK_CODE;
      len_sel = LEN_HDR;
      // R09 unused octets zero
      pay_sel = '0;
    end
  end

  // Control: capture, decide, emit; nothing outside this path is touched
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    type_next = type_reg;
    sub_next = sub_reg;
    id_next = id_reg;
    resp_next = resp_reg;
    left_next = left_reg;
    // R24 accept only when idle
    cmd_ready = ce && (state_reg == PTR_IDLE);
    fifo_in_valid = ce && (state_reg == PTR_EMIT);
    fifo_in_data = {left_reg == 6'h01, resp_reg[RESP_W-1 -: OCTET_W]};
    // R19 subcarrier index
    sc_idx_next = SC_IDX_W'(group_size * group_index);
    unique case (state_reg)
      PTR_IDLE: begin
        if (cmd_valid) begin
          // Octets past the third only count, so overlong requests are refused
          if (cnt_reg == 3'h0) type_next = cmd_data;
          if (cnt_reg == 3'h1) sub_next = cmd_data;
          if (cnt_reg == 3'h2) id_next = cmd_data;
          if (cnt_reg != REQ_LEN_MAX) cnt_next = cnt_reg + 3'h1;
          if (cmd_last) state_next = PTR_DECIDE;
        end
      end
      PTR_DECIDE: begin
        // R01 response always built
        // R03 isolated from other logic
        resp_next = {type_reg, code_sel, pay_sel};
        left_next = len_sel;
        cnt_next = 3'h0;
        state_next = PTR_EMIT;
      end
      PTR_EMIT: begin
        // R23 advance only when taken
        if (fifo_in_ready) begin
          resp_next = {resp_reg[RESP_W-OCTET_W-1:0], RESERVED_OCTET};
          left_next = left_reg - 6'h01;
          if (left_reg == 6'h01) state_next = PTR_IDLE;
        end
      end
    endcase
  end

  // Register stage; ce low freezes everything
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= PTR_IDLE;
      cnt_reg <= 3'h0;
      type_reg <= 8'h00;
      sub_reg <= 8'h00;
      id_reg <= 8'h00;
      resp_reg <= '0;
      left_reg <= 6'h00;
      sc_idx_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      type_reg <= type_next;
      sub_reg <= sub_next;
      id_reg <= id_next;
      resp_reg <= resp_next;
      left_reg <= left_next;
      sc_idx_reg <= sc_idx_next;
    end
  end

  // Output buffer decouples emission from transmitter stalls
  ptr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  always_comb begin
    tx_data = fifo_out_data[OCTET_W-1:0];
    tx_last = fifo_out_data[OCTET_W];
    busy = (state_reg != PTR_IDLE);
    subcarrier_index = sc_idx_reg;
  end

  // Checks on decode and handshake
  cmd_block_a: assert property (@(posedge sys_clk) disable iff (rst) // R24
    (state_reg != PTR_IDLE) |-> !cmd_ready) else $error("command taken while busy");
  tx_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R23
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("octet dropped");
  nack_len_a: assert property (@(posedge sys_clk) disable iff (rst) // R22
    ce && state_reg == PTR_DECIDE && !single_ok && !scalar_ok |=>
    left_reg == LEN_HDR && resp_reg[PAYLOAD_W+7 -: 8] == NACK_CODE) else $error("bad nack");
  single_code_a: assert property (@(posedge sys_clk) disable iff (rst) // R20
    ce && state_reg == PTR_DECIDE && single_ok |=> resp_reg[PAYLOAD_W+7 -: 8] == ACK_SINGLE
    && left_reg == ($past(improved_rate_mode) ? LEN_SINGLE_IMPR : LEN_SINGLE_BASIC))
    else $error("bad single ack");
  reserved_id_a: assert property (@(posedge sys_clk) disable iff (rst) // R18
    ce && state_reg == PTR_DECIDE && sub_reg == CMD_SCALAR && (id_reg < ID_LOOP_LOSS
    || id_reg > ID_ROBUST) |=> resp_reg[PAYLOAD_W+7 -: 8] == NACK_CODE)
    else $error("reserved id answered");
  bearer_off_a: assert property (@(posedge sys_clk) disable iff (rst) // R17
    ce && state_reg == PTR_DECIDE && scalar_ok && id_reg == ID_IMPULSE && !bearer_enable[0]
    |=> resp_reg[PAYLOAD_W-1 -: 8] == DISABLED_BEARER) else $error("bearer not FF");
  band_off_a: assert property (@(posedge sys_clk) disable iff (rst) // R08
    ce && state_reg == PTR_DECIDE && single_ok && !downstream_dir && !band_enable[1]
    |=> resp_reg[PAYLOAD_W-17 -: 16] == DISABLED_BAND) else $error("disabled band nonzero");
  ds_reserved_a: assert property (@(posedge sys_clk) disable iff (rst) // R07
    ce && state_reg == PTR_DECIDE && single_ok && downstream_dir
    |=> resp_reg[PAYLOAD_W-65 -: 16] == 16'h0000) else $error("reserved slot nonzero");
  impr_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    ce && state_reg == PTR_DECIDE && single_ok && improved_rate_mode
    |=> resp_reg[63:56] == RESERVED_OCTET && resp_reg[47:40] == RESERVED_OCTET)
    else $error("improved reserved nonzero");
  emit_end_a: assert property (@(posedge sys_clk) disable iff (rst) // R01
    ce && state_reg == PTR_EMIT && fifo_in_ready && left_reg == 6'h01 |=> state_reg == PTR_IDLE)
    else $error("response not closed");

  single_c: cover property (@(posedge sys_clk) state_reg == PTR_DECIDE && single_ok);
  scalar_c: cover property (@(posedge sys_clk) state_reg == PTR_DECIDE && scalar_ok);
  nack_c: cover property (@(posedge sys_clk) state_reg == PTR_DECIDE && !single_ok && !scalar_ok);
  stall_c: cover property (@(posedge sys_clk) state_reg == PTR_EMIT && !fifo_in_ready);
endmodule : ptr_responder
